//--- dv/lr3_regs_tb.sv
`timescale 1ns/100ps
module lr3_regs_tb;
  // Register map row: address, written word, word read back
  typedef struct {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } lr3_row_t;

  logic        sys_clk;            // 200 MHz system clock
  logic        rst;                // Synchronous reset
  logic        hsel;               // Bus select
  logic [31:0] haddr;              // Bus byte address
  logic [1:0]  htrans;             // Transfer kind
  logic        hwrite;             // Write strobe
  logic [2:0]  hsize;              // Word only
  logic [31:0] hwdata;             // Write data
  logic        hreadyout;          // Slave ready, fed back
  logic        hresp;              // Always OKAY
  logic [31:0] hrdata;             // Read data
  logic        hc1;                // Hardware control one
  logic        hc2;                // Hardware control two
  logic        hen1;               // Hardware enable one
  logic        hen2;               // Hardware enable two
  logic        uv;                 // Undervoltage level
  logic [2:0]  seq_timeslot;       // Sequencer step
  logic        seq_startup_strobe; // Startup step pulse
  logic        seq_sleep_strobe;   // Sleep step pulse
  logic        reg_enable;         // Regulator on
  logic        reg_low_power;      // Low power mode
  logic        lp_variant_sel;     // 50mA or 20mA variant
  logic [4:0]  vsel_code;          // Applied voltage code
  logic [11:0] target_mv;          // Applied millivolts
  logic        discharge_en;       // Output pulled down
  logic        switch_mode;        // Switch operation
  logic        device_reset_req;   // Whole-device reset pulse
  logic        irq;                // Interrupt level
  int          errors;             // Mismatch count
  int          n_compared;         // Comparison count
  int          n_pulse;            // Device reset pulses seen
  logic [31:0] rdv;                // Scratch read value
  logic [11:0] mv;                 // Expected millivolts
  lr3_row_t    rows [5];           // Map cases

  lr3_regs dut_u (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hw_ctrl1_pin(hc1), .hw_ctrl2_pin(hc2),
    .hw_en1_pin(hen1), .hw_en2_pin(hen2), .undervolt_pin(uv),
    .seq_timeslot(seq_timeslot), .seq_startup_strobe(seq_startup_strobe),
    .seq_sleep_strobe(seq_sleep_strobe), .reg_enable(reg_enable),
    .reg_low_power(reg_low_power), .lp_variant_sel(lp_variant_sel),
    .vsel_code(vsel_code), .target_mv(target_mv),
    .discharge_en(discharge_en), .switch_mode(switch_mode),
    .device_reset_req(device_reset_req), .irq(irq)
  );

  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Device reset pulses are counted, not sampled, as they last one cycle
  always @(posedge sys_clk) begin
    if (device_reset_req === 1'b1) n_pulse++;
  end

  // Verdict and end of run
  task close_out;
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compare one value
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single transfer; waits for ready in both phases
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= lr3_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rdv);
  endtask

  task rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, rdv);
    chk(rdv, e);
    chk(32'({hreadyout, hresp}), 32'h0000_0002);
  endtask

  // Let registered outputs land, then sample off the edge
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Sequencer step pulse of one cycle
  task step(input logic [2:0] ts, input logic slp);
    @(posedge sys_clk);
    seq_timeslot       <= ts;
    seq_startup_strobe <= !slp;
    seq_sleep_strobe   <= slp;
    @(posedge sys_clk);
    seq_startup_strobe <= 1'b0;
    seq_sleep_strobe   <= 1'b0;
    tick(3);
  endtask

  // Undervoltage rising edge, then long enough low for the next edge
  task uv_event;
    @(posedge sys_clk);
    uv <= 1'b1;
    tick(6);
    uv <= 1'b0;
    tick(4);
  endtask

  // Hang guard, well past the expected run
  initial begin
    #200000;
    errors++;
    close_out();
  end

  initial begin
    {hsel, hwrite, hc1, hc2, hen1, hen2, uv} = 7'h00;
    {seq_startup_strobe, seq_sleep_strobe} = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    seq_timeslot = 3'h0;
    {errors, n_compared, n_pulse} = 0;
    rows = '{'{lr3_pkg::ADDR_CTRL, 32'h0000_FFFF, 32'h0000_DFC1},
             '{lr3_pkg::ADDR_ON, 32'hFFFF_FFFF, 32'h0000_E11F},
             '{lr3_pkg::ADDR_SLP, 32'h0000_FFFF, 32'h0000_E11F},
             '{lr3_pkg::ADDR_MASK, 32'h0000_FFFF, 32'h0000_0003},
             '{32'h0001_0100, 32'h0000_FFFF, 32'h0000_0000}};
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    // Idle outputs after reset: off and discharged at 0.90V
    chk(32'(target_mv), 32'h0000_0384);
    chk(32'({reg_enable, discharge_en, irq}), 32'h0000_0002);
    rdc(lr3_pkg::ADDR_CTRL, 32'h0000_0200);
    rdc(lr3_pkg::ADDR_ON, 32'h0000_0000);
    rdc(lr3_pkg::ADDR_SLP, 32'h0000_0100);
    // Undefined bits and unmapped places read zero
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_0000);
    // Every voltage code, both step sizes and the split point
    for (int c = 0; c < 32; c++) begin
      wr(lr3_pkg::ADDR_ON, 32'(c));
      tick(3);
      mv = (c < 15) ? 12'(900 + 50 * c) : 12'(1700 + 100 * (c - 15));
      chk(32'(vsel_code), 32'(c));
      chk(32'(target_mv), 32'(mv));
    end
    // Float, switch and low power variant bits reach the outputs
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_00C1);
    tick(3);
    chk(32'({discharge_en, switch_mode, lp_variant_sel}), 32'h3);
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_0000);
    // Start in slot two only, low power ON mode
    wr(lr3_pkg::ADDR_ON, 32'h0000_4105);
    step(3'h1, 1'b0);
    chk(32'(reg_enable), 32'h0);
    step(3'h2, 1'b0);
    chk(32'({reg_enable, reg_low_power}), 32'h3);
    chk(32'(vsel_code), 32'h5);
    // Source one only: control two is ignored, control one turns off
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_0900);
    @(posedge sys_clk);
    hc2 <= 1'b1;
    tick(6);
    chk(32'(reg_enable), 32'h1);
    hc1 <= 1'b1;
    tick(6);
    chk(32'(reg_enable), 32'h0);
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_0C00);
    tick(3);
    chk(32'({reg_enable, reg_low_power}), 32'h3);
    chk(32'(vsel_code), 32'h1F);
    @(posedge sys_clk);
    {hc1, hc2} <= 2'h0;
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_0000);
    // Sleep code three disables in timeslot three only
    wr(lr3_pkg::ADDR_SLP, 32'h0000_6000);
    step(3'h5, 1'b1);
    chk(32'(reg_enable), 32'h1);
    step(3'h3, 1'b1);
    chk(32'({reg_enable, discharge_en}), 32'h1);
    // Shutdown on undervoltage, interrupt, write-one clear
    step(3'h2, 1'b0);
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_4000);
    uv_event();
    chk(32'({reg_enable, irq}), 32'h1);
    rdc(lr3_pkg::ADDR_STAT, 32'h0000_0003);
    wr(lr3_pkg::ADDR_STAT, 32'h0000_0003);
    tick(2);
    chk(32'(irq), 32'h0);
    // Ignored event still flags status; mask gates the line
    wr(lr3_pkg::ADDR_MASK, 32'h0000_0000);
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_0000);
    uv_event();
    chk(32'(irq), 32'h0);
    rdc(lr3_pkg::ADDR_STAT, 32'h0000_0001);
    wr(lr3_pkg::ADDR_MASK, 32'h0000_0001);
    tick(2);
    chk(32'(irq), 32'h1);
    wr(lr3_pkg::ADDR_STAT, 32'h0000_0001);
    // Device reset action gives exactly one pulse
    wr(lr3_pkg::ADDR_CTRL, 32'h0000_8000);
    uv_event();
    chk(32'(n_pulse), 32'h1);
    // Reset in mid-run restores the defaults
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(lr3_pkg::ADDR_CTRL, 32'h0000_0200);
    // Sleep code zero enters SLEEP in slot five with sleep mode and code
    wr(lr3_pkg::ADDR_ON, 32'h0000_2003);
    wr(lr3_pkg::ADDR_SLP, 32'h0000_0107);
    step(3'h1, 1'b0);
    step(3'h5, 1'b1);
    chk(32'({reg_enable, reg_low_power, vsel_code}), 32'h0000_0067);
    // Hardware enable one slot follows its pin, low turns off
    wr(lr3_pkg::ADDR_ON, 32'h0000_C000);
    tick(3);
    chk(32'(reg_enable), 32'h0000_0000);
    @(posedge sys_clk);
    hen1 <= 1'b1;
    tick(6);
    chk(32'(reg_enable), 32'h0000_0001);
    @(posedge sys_clk);
    hen1 <= 1'b0;
    tick(6);
    chk(32'(reg_enable), 32'h0000_0000);
    close_out();
  end
endmodule

//--- hdl/lr3_mv.sv
`timescale 1ns/100ps
// Voltage code to millivolt target, registered
module lr3_mv (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  code,
  output logic      [11:0] mv
);

  // Two linear segments split at the step change
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mv <= lr3_pkg::MV_LO_BASE;
    end else if (code < lr3_pkg::CODE_SPLIT) begin
      mv <= lr3_pkg::MV_LO_BASE + 12'(code) * lr3_pkg::MV_LO_STEP; // see R10
    end else begin
      mv <= lr3_pkg::MV_HI_BASE
            + 12'(code - lr3_pkg::CODE_SPLIT) * lr3_pkg::MV_HI_STEP; // see R10
    end
  end

  default clocking mv_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  split_code_a: assert property (code == lr3_pkg::CODE_SPLIT // see R10
    |=> mv == 12'h6A4) else $error("Code 0Fh not 1700 mV");
  top_code_a: assert property (code == 5'h1F // see R10
    |=> mv == 12'hCE4) else $error("Code 1Fh not 3300 mV");

endmodule

//--- hdl/lr3_pkg.sv
// How it works
// R1 - Undervoltage response: ignore, shut down, device reset
// R2 - Every undervoltage event raises an interrupt; each sets the status bit, irq only if its mask bit is set
// R3 - Control source picks which hardware inputs govern
// R4 - Under hardware control, choose ON or SLEEP voltage
// R5 - Hardware mode: low power, off, or ON mode
// R6 - Off output discharged or floating; switch select
// R7 - Low power variant: 50mA or 20mA
// R8 - ON slot: never, timeslot 1-5, hardware enable
// R9 - ON state mode bit: normal or low power
// R10 - Voltage code maps to 50mV then 100mV steps
// R11 - Sleep slot: transition or disable per timeslot
// R12 - Undefined bits read zero, ignore writes
package lr3_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL = 16'h406E;
  localparam logic [15:0] IDX_ON   = 16'h406F;
  localparam logic [15:0] IDX_SLP  = 16'h4070;
  localparam logic [31:0] ADDR_CTRL = {14'h0000, IDX_CTRL, 2'b00};
  localparam logic [31:0] ADDR_ON   = {14'h0000, IDX_ON, 2'b00};
  localparam logic [31:0] ADDR_SLP  = {14'h0000, IDX_SLP, 2'b00};
  localparam logic [31:0] ADDR_STAT = 32'h0001_0200; // Sticky events
  localparam logic [31:0] ADDR_MASK = 32'h0001_0204; // Interrupt mask

  // Writable bit masks and reset values
  localparam logic [15:0] CTRL_WMASK = 16'hDFC1;
  localparam logic [15:0] SLOT_WMASK = 16'hE11F;
  localparam logic [15:0] CTRL_RST   = 16'h0200;
  localparam logic [15:0] ON_RST     = 16'h0000;
  localparam logic [15:0] SLP_RST    = 16'h0100;

  // Field positions
  localparam int ERR_LSB   = 14;
  localparam int SRC_LSB   = 11;
  localparam int VCH_BIT   = 10;
  localparam int HMODE_LSB = 8;
  localparam int FLT_BIT   = 7;
  localparam int SWI_BIT   = 6;
  localparam int LPV_BIT   = 0;
  localparam int SLOT_LSB  = 13;
  localparam int MODE_BIT  = 8;
  localparam int VSEL_LSB  = 0;

  // Field encodings
  localparam logic [1:0] ERR_IGNORE   = 2'h0;
  localparam logic [1:0] ERR_SHUTDOWN = 2'h1;
  localparam logic [1:0] ERR_RESET    = 2'h2;
  localparam logic [1:0] SRC_NONE     = 2'h0;
  localparam logic [1:0] SRC_ONE      = 2'h1;
  localparam logic [1:0] SRC_TWO      = 2'h2;
  localparam logic [1:0] SRC_ANY      = 2'h3;
  localparam logic [1:0] HMODE_LP0    = 2'h0;
  localparam logic [1:0] HMODE_OFF    = 2'h1;
  localparam logic [1:0] HMODE_FOLLOW = 2'h3;
  localparam logic [2:0] SLOT_NEVER   = 3'h0;
  localparam logic [2:0] SLOT_LAST    = 3'h5;
  localparam logic [2:0] SLOT_HEN1    = 3'h6;
  localparam logic [2:0] SLOT_HEN2    = 3'h7;
  localparam logic [2:0] SLP_SUM      = 3'h6; // Disable slot = 6 - code
  localparam logic [2:0] TS_ONE       = 3'h1;
  localparam logic [2:0] TS_THREE     = 3'h3;
  localparam logic [2:0] TS_FIVE      = 3'h5;

  // Interrupt status bits
  localparam int IRQ_W     = 2;
  localparam int IRQ_UV    = 0;
  localparam int IRQ_FAULT = 1;

  // Voltage table in millivolts
  localparam logic [4:0]  CODE_SPLIT = 5'h0F;
  localparam logic [11:0] MV_LO_BASE = 12'h384; // 900 mV
  localparam logic [11:0] MV_LO_STEP = 12'h032; // 50 mV
  localparam logic [11:0] MV_HI_BASE = 12'h6A4; // 1700 mV
  localparam logic [11:0] MV_HI_STEP = 12'h064; // 100 mV

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Regulator power state, Gray along off, on, sleep
  typedef enum logic [1:0] {
    LR3_OFF   = 2'b00,
    LR3_ON    = 2'b01,
    LR3_SLEEP = 2'b11,
    LR3_FAULT = 2'b10
  } lr3_state_t;

endpackage

//--- hdl/lr3_regs.sv
`timescale 1ns/100ps
// Regulator three control registers and power state
module lr3_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        hw_ctrl1_pin,
  input  wire logic        hw_ctrl2_pin,
  input  wire logic        hw_en1_pin,
  input  wire logic        hw_en2_pin,
  input  wire logic        undervolt_pin,
  input  wire logic [2:0]  seq_timeslot,
  input  wire logic        seq_startup_strobe,
  input  wire logic        seq_sleep_strobe,
  output logic             reg_enable,
  output logic             reg_low_power,
  output logic             lp_variant_sel,
  output logic      [4:0]  vsel_code,
  output logic      [11:0] target_mv,
  output logic             discharge_en,
  output logic             switch_mode,
  output logic             device_reset_req,
  output logic             irq
);

  // Pin synchronisers, first stage read only by second
  logic [4:0] sync1_reg;             // First stage
  logic [4:0] sync2_reg;             // Stable copy
  logic       hc1, hc2, hen1, hen2;  // Synchronised pins
  logic       uv_lvl;                // Undervoltage level
  logic       uv_prev_reg;           // For edge detect
  logic       uv_event;              // One cycle per undervoltage

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {undervolt_pin, hw_en2_pin, hw_en1_pin,
                    hw_ctrl2_pin, hw_ctrl1_pin};
      sync2_reg <= sync1_reg;
    end
  end

  assign hc1    = sync2_reg[0];
  assign hc2    = sync2_reg[1];
  assign hen1   = sync2_reg[2];
  assign hen2   = sync2_reg[3];
  assign uv_lvl = sync2_reg[4];

  // Rising edge of undervoltage is the event
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv_prev_reg <= 1'b0;
    end else begin
      uv_prev_reg <= uv_lvl;
    end
  end

  assign uv_event = uv_lvl & ~uv_prev_reg;

  // Bus address phase capture
  logic        addr_ph;        // Accepted address phase
  logic        dp_write_reg;   // Write data phase pending
  logic [31:0] dp_addr_reg;    // Address of pending write

  assign addr_ph = hsel & hready & (htrans == lr3_pkg::HTRANS_NONSEQ);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 32'h0000_0000;
    end else begin
      dp_write_reg <= addr_ph & hwrite;
      dp_addr_reg  <= haddr;
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= lr3_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= lr3_pkg::HRESP_OKAY;
    end
  end

  // Register storage and next values
  logic [15:0]            ctrl_reg, ctrl_next;   // Control
  logic [15:0]            on_reg, on_next;       // ON state setup
  logic [15:0]            slp_reg, slp_next;     // SLEEP state setup
  logic [lr3_pkg::IRQ_W-1:0] stat_reg, stat_next; // Sticky events
  logic [lr3_pkg::IRQ_W-1:0] mask_reg, mask_next; // Interrupt enables
  logic [lr3_pkg::IRQ_W-1:0] events;             // This cycle's events
  logic                   wr_ctrl, wr_on, wr_slp, wr_stat, wr_mask;

  assign wr_ctrl = dp_write_reg & (dp_addr_reg == lr3_pkg::ADDR_CTRL);
  assign wr_on   = dp_write_reg & (dp_addr_reg == lr3_pkg::ADDR_ON);
  assign wr_slp  = dp_write_reg & (dp_addr_reg == lr3_pkg::ADDR_SLP);
  assign wr_stat = dp_write_reg & (dp_addr_reg == lr3_pkg::ADDR_STAT);
  assign wr_mask = dp_write_reg & (dp_addr_reg == lr3_pkg::ADDR_MASK);

  // Undefined bits are masked on every write
  always_comb begin
    ctrl_next = wr_ctrl ? (hwdata[15:0] & lr3_pkg::CTRL_WMASK)
                        : ctrl_reg; // see R12
    on_next   = wr_on ? (hwdata[15:0] & lr3_pkg::SLOT_WMASK) : on_reg;
    slp_next  = wr_slp ? (hwdata[15:0] & lr3_pkg::SLOT_WMASK) : slp_reg;
    mask_next = wr_mask ? hwdata[lr3_pkg::IRQ_W-1:0] : mask_reg;
    // Write one clears; a new event wins over the clear
    stat_next = (stat_reg & ~(wr_stat ? hwdata[lr3_pkg::IRQ_W-1:0]
                                      : {lr3_pkg::IRQ_W{1'b0}}))
                | events; // see R2
  end

  // Register update
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= lr3_pkg::CTRL_RST;
      on_reg   <= lr3_pkg::ON_RST;
      slp_reg  <= lr3_pkg::SLP_RST;
      stat_reg <= {lr3_pkg::IRQ_W{1'b0}};
      mask_reg <= {lr3_pkg::IRQ_W{1'b0}};
    end else begin
      ctrl_reg <= ctrl_next;
      on_reg   <= on_next;
      slp_reg  <= slp_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  // Read mux uses next values so a read right after a write sees it
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case (haddr)
      lr3_pkg::ADDR_CTRL: rd_data = {16'h0000, ctrl_next};
      lr3_pkg::ADDR_ON:   rd_data = {16'h0000, on_next};
      lr3_pkg::ADDR_SLP:  rd_data = {16'h0000, slp_next};
      lr3_pkg::ADDR_STAT: rd_data = {30'h0000_0000, stat_next};
      lr3_pkg::ADDR_MASK: rd_data = {30'h0000_0000, mask_next};
      default:            rd_data = 32'h0000_0000; // Unmapped reads zero
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ph & ~hwrite) begin
      hrdata <= rd_data;
    end
  end

  // Field views
  logic [1:0] err_act, hw_src, hw_mode;
  logic       hw_vch, on_mode, slp_mode;
  logic [2:0] on_slot, slp_slot;
  logic [4:0] on_v, slp_v;

  assign err_act  = ctrl_reg[lr3_pkg::ERR_LSB +: 2];
  assign hw_src   = ctrl_reg[lr3_pkg::SRC_LSB +: 2];
  assign hw_vch   = ctrl_reg[lr3_pkg::VCH_BIT];
  assign hw_mode  = ctrl_reg[lr3_pkg::HMODE_LSB +: 2];
  assign on_slot  = on_reg[lr3_pkg::SLOT_LSB +: 3];
  assign on_mode  = on_reg[lr3_pkg::MODE_BIT];
  assign on_v     = on_reg[lr3_pkg::VSEL_LSB +: 5];
  assign slp_slot = slp_reg[lr3_pkg::SLOT_LSB +: 3];
  assign slp_mode = slp_reg[lr3_pkg::MODE_BIT];
  assign slp_v    = slp_reg[lr3_pkg::VSEL_LSB +: 5];

  // Timeslot in which the sleep action happens
  function automatic logic [2:0] sleep_ts(input logic [2:0] code);
    case (code)
      3'h0:    sleep_ts = lr3_pkg::TS_FIVE;
      3'h6:    sleep_ts = lr3_pkg::TS_THREE;
      3'h7:    sleep_ts = lr3_pkg::TS_ONE;
      default: sleep_ts = lr3_pkg::SLP_SUM - code;
    endcase
  endfunction

  // Codes one to five disable rather than enter sleep
  function automatic logic sleep_disables(input logic [2:0] code);
    sleep_disables = (code != lr3_pkg::SLOT_NEVER)
                     & (code <= lr3_pkg::SLOT_LAST);
  endfunction

  // Hardware enable assignment and control source
  logic hen_mode, hen_level, hwc_active, on_match, slp_match;

  assign hen_mode  = (on_slot == lr3_pkg::SLOT_HEN1)
                   | (on_slot == lr3_pkg::SLOT_HEN2); // see R8
  assign hen_level = (on_slot == lr3_pkg::SLOT_HEN1) ? hen1 : hen2;
  assign on_match  = seq_startup_strobe & (on_slot != lr3_pkg::SLOT_NEVER)
                   & (seq_timeslot == on_slot); // see R8
  assign slp_match = seq_sleep_strobe
                   & (seq_timeslot == sleep_ts(slp_slot)); // see R11

  always_comb begin
    case (hw_src) // see R3
      lr3_pkg::SRC_ONE: hwc_active = hc1;
      lr3_pkg::SRC_TWO: hwc_active = hc2;
      lr3_pkg::SRC_ANY: hwc_active = hc1 | hc2;
      default:          hwc_active = 1'b0;
    endcase
  end

  // Power state machine
  lr3_pkg::lr3_state_t state_reg, state_next;
  logic                uv_shut;  // Undervoltage asks for shutdown

  assign uv_shut = uv_event & (err_act == lr3_pkg::ERR_SHUTDOWN)
                 & (state_reg != lr3_pkg::LR3_FAULT); // see R1

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lr3_pkg::LR3_OFF: begin
        if (hen_mode ? hen_level : on_match) begin
          state_next = lr3_pkg::LR3_ON; // see R8
        end
      end
      lr3_pkg::LR3_ON: begin
        if (hen_mode & ~hen_level) begin
          state_next = lr3_pkg::LR3_OFF;
        end else if (slp_match) begin
          // Hardware enabled regulators only sleep, never disable
          state_next = (sleep_disables(slp_slot) & ~hen_mode)
                     ? lr3_pkg::LR3_OFF : lr3_pkg::LR3_SLEEP; // see R11
        end
      end
      lr3_pkg::LR3_SLEEP: begin
        if (hen_mode & ~hen_level) begin
          state_next = lr3_pkg::LR3_OFF;
        end else if (hen_mode ? seq_startup_strobe : on_match) begin
          state_next = lr3_pkg::LR3_ON;
        end
      end
      lr3_pkg::LR3_FAULT: begin
        // Held off until software acknowledges the shutdown
        if (!stat_reg[lr3_pkg::IRQ_FAULT]) begin
          state_next = lr3_pkg::LR3_OFF;
        end
      end
      default: state_next = lr3_pkg::LR3_OFF;
    endcase
    if (uv_shut) begin
      state_next = lr3_pkg::LR3_FAULT; // see R1
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= lr3_pkg::LR3_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Interrupt events: every undervoltage, and fault shutdown
  always_comb begin
    events                     = {lr3_pkg::IRQ_W{1'b0}};
    events[lr3_pkg::IRQ_UV]    = uv_event; // see R2
    events[lr3_pkg::IRQ_FAULT] = uv_shut;
  end

  // Regulator drive decisions
  logic       hw_off, en_c, lp_c;
  logic [4:0] vsel_c;

  assign hw_off = hwc_active & (hw_mode == lr3_pkg::HMODE_OFF); // see R5
  assign en_c   = ((state_reg == lr3_pkg::LR3_ON)
                 | (state_reg == lr3_pkg::LR3_SLEEP)) & ~hw_off;

  always_comb begin
    if (hwc_active) begin
      lp_c   = (hw_mode == lr3_pkg::HMODE_FOLLOW) ? on_mode : 1'b1; // see R5
      vsel_c = hw_vch ? slp_v : on_v; // see R4
    end else if (state_reg == lr3_pkg::LR3_SLEEP) begin
      lp_c   = slp_mode;
      vsel_c = slp_v;
    end else begin
      lp_c   = on_mode; // see R9
      vsel_c = on_v;
    end
  end

  // Output flops; discharge only when off and not floating
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_enable       <= 1'b0;
      reg_low_power    <= 1'b0;
      lp_variant_sel   <= 1'b0;
      vsel_code        <= 5'h00;
      discharge_en     <= 1'b1;
      switch_mode      <= 1'b0;
      device_reset_req <= 1'b0;
      irq              <= 1'b0;
    end else begin
      reg_enable       <= en_c;
      reg_low_power    <= lp_c;
      lp_variant_sel   <= ctrl_reg[lr3_pkg::LPV_BIT]; // see R7
      vsel_code        <= vsel_c;
      discharge_en     <= ~en_c & ~ctrl_reg[lr3_pkg::FLT_BIT]; // see R6
      switch_mode      <= ctrl_reg[lr3_pkg::SWI_BIT]; // see R6
      device_reset_req <= uv_event & (err_act == lr3_pkg::ERR_RESET); // see R1
      irq              <= |(stat_next & mask_next);
    end
  end

  // Millivolt target tracks the selected code
  lr3_mv u_mv (
    .sys_clk (sys_clk),
    .rst     (rst),
    .code    (vsel_c),
    .mv      (target_mv)
  );

  default clocking main_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  dev_reset_a: assert property ( // see R1
    uv_event ##0 err_act == lr3_pkg::ERR_RESET
    |=> device_reset_req ##1 !device_reset_req)
    else $error("Device reset request not one pulse");
  shut_down_a: assert property (uv_shut // see R1
    |=> state_reg == lr3_pkg::LR3_FAULT ##1 !reg_enable)
    else $error("Undervoltage shutdown not taken");
  uv_irq_a: assert property (uv_event |=> stat_reg[lr3_pkg::IRQ_UV]) // see R2
    else $error("Undervoltage event lost");
  hw_off_a: assert property (hwc_active // see R5
    && hw_mode == lr3_pkg::HMODE_OFF |=> !reg_enable)
    else $error("Hardware off mode ignored");
  hw_lp_a: assert property (hwc_active // see R5
    && hw_mode == lr3_pkg::HMODE_LP0 |=> reg_low_power)
    else $error("Hardware low power not applied");
  hw_vsel_a: assert property (hwc_active && hw_vch // see R4
    |=> vsel_code == $past(slp_v))
    else $error("Hardware voltage choice wrong");
  src_none_a: assert property (hw_src == lr3_pkg::SRC_NONE // see R3
    && state_reg == lr3_pkg::LR3_ON |=> reg_enable)
    else $error("Disabled control source acted");
  on_mode_a: assert property (state_reg == lr3_pkg::LR3_ON // see R9
    && !hwc_active |=> reg_low_power == $past(on_mode))
    else $error("ON mode bit not applied");
  never_on_a: assert property (state_reg == lr3_pkg::LR3_OFF // see R8
    && on_slot == lr3_pkg::SLOT_NEVER |=> state_reg != lr3_pkg::LR3_ON)
    else $error("Regulator enabled with slot never");
  // Enable lands one edge after the ON state, gated by that cycle's off
  slot_on_a: assert property (state_reg == lr3_pkg::LR3_OFF // see R8
    && !hen_mode && on_match && !uv_shut
    |=> state_reg == lr3_pkg::LR3_ON ##1 (reg_enable || $past(hw_off)))
    else $error("Start-up timeslot missed");
  sleep_dis_a: assert property (state_reg == lr3_pkg::LR3_ON // see R11
    && !hen_mode && !uv_shut && slp_match && sleep_disables(slp_slot)
    |=> state_reg == lr3_pkg::LR3_OFF)
    else $error("Sleep slot did not disable");
  float_a: assert property (discharge_en // see R6
    |-> !reg_enable && !$past(ctrl_reg[lr3_pkg::FLT_BIT]))
    else $error("Discharge while on or floating");
  reserved_a: assert property ( // see R12
    (ctrl_reg & ~lr3_pkg::CTRL_WMASK) == 16'h0000
    && (on_reg & ~lr3_pkg::SLOT_WMASK) == 16'h0000)
    else $error("Undefined bit became set");
  lp_var_a: assert property (##1 lp_variant_sel // see R7
    == $past(ctrl_reg[lr3_pkg::LPV_BIT]))
    else $error("Low power variant not tracking");

  fault_c: cover property (uv_shut ##1 state_reg == lr3_pkg::LR3_FAULT);
  sleep_c: cover property (state_reg == lr3_pkg::LR3_ON
    ##1 state_reg == lr3_pkg::LR3_SLEEP);
  hw_off_c: cover property (reg_enable ##1 hw_off ##1 !reg_enable);
  irq_c: cover property (!irq ##1 irq);

endmodule
